// ==== verilog/ioc_gearbox_io.sv ====
// Pin I/O register cell with output DDR logic, input DDR capture, input gearbox and its FIFO.
// Assumes all link clocks and strobes are far slower than aclk, so sampled edges are never missed.
//
// Notes on behaviour
// - Every core data bit is registered before it reaches the pin driver.
// - Single-rate output uses one element, either an edge register or transparent latch.
// - Double-rate output captures both inputs on rise, moves second to fall hold on fall.
// - Generic double-rate output multiplexes rise and fall hold by the same clock.
// - Memory double-rate output multiplexes the hold registers by the shifted write strobe.
// - Strobe memory modes exist only on right-edge cells; elsewhere they fall back to generic.
// - Memory input samples the pin on both edges of the shifted read strobe.
// - Both strobe-domain streams are resynchronised to the system clock before the core.
// - A polarity control picks which system clock edge clocks the resynchronisation.
// - Read strobe and polarity arrive from the separate strobe control block.
// - The input gearbox is three register stages from pin to its FIFO, which feeds the core.
// - Gearbox stage one samples the pin on both edges of the edge clock.
// - Gearbox stage two aligns data by update and select from a control block.
// - Gearbox stage three hands the aligned word to the FIFO on the rising system clock edge.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none

module ioc_fifo #(
    parameter int WIDTH = ioc_pkg::GB_RATIO,
    parameter int DEPTH = ioc_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // Filling side.
    input  wire logic [WIDTH-1:0]            in_data,
    input  wire logic                        in_valid,
    output logic                             in_ready,
    // Draining side.
    output logic [WIDTH-1:0]                 out_data,
    output logic                             out_valid,
    input  wire logic                        out_ready,
    // Fill level.
    output logic [$clog2(DEPTH+1)-1:0]       level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] count;
    } ioc_fifo_state_t;

    ioc_fifo_state_t  q;
    ioc_fifo_state_t  n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = q.count != CW'(DEPTH);
    assign out_valid = q.count != '0;
    assign out_data  = mem[q.rptr];
    assign level     = q.count;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        n = q;
        if (push) begin
            n.wptr = (q.wptr == AW'(DEPTH - 1)) ? '0 : q.wptr + 1'b1;
        end
        if (pop) begin
            n.rptr = (q.rptr == AW'(DEPTH - 1)) ? '0 : q.rptr + 1'b1;
        end
        n.count = q.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
        if (push) begin
            mem[q.wptr] <= in_data;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    fifo_full_a: assert property (q.count == CW'(DEPTH) |-> !in_ready)
        else $error("fifo accepts data while full");
    fifo_count_a: assert property (push && !pop |=> q.count == $past(q.count) + 1'b1)
        else $error("fifo level did not grow on a lone push");

endmodule : ioc_fifo

module ioc_gearbox_io #(
    parameter bit RIGHT_EDGE = 1'b1,
    parameter int FIFO_DEPTH = ioc_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite register slave.
    input  wire logic [ioc_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [ioc_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Link clocks, strobes and pin, all asynchronous to aclk.
    input  wire logic                          sys_clk_in,
    input  wire logic                          edge_clk_in,
    input  wire logic                          read_strobe_shifted,
    input  wire logic                          write_strobe_shifted,
    input  wire logic                          sync_clock_polarity,
    input  wire logic                          pin_in,
    // Pin driver.
    output logic                               pin_out,
    output logic                               pin_oe_n,
    // Core side, double-rate data.
    input  wire logic                          rise_data_in,
    input  wire logic                          fall_data_in,
    output logic                               rise_data_out,
    output logic                               fall_data_out,
    // Core side, gearbox control and word stream.
    input  wire logic                          gb_update,
    input  wire logic                          align_select,
    output logic [ioc_pkg::GB_RATIO-1:0]       gb_data,
    output logic                               gb_valid,
    input  wire logic                          gb_ready
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    ioc_pkg::ioc_state_t q;
    ioc_pkg::ioc_state_t n;
    ioc_pkg::ioc_link_t  link_in;
    ioc_pkg::ioc_link_t  lv;
    ioc_pkg::ioc_link_t  lr;
    ioc_pkg::ioc_link_t  lf;
    logic [1:0]          omode;
    logic [1:0]          imode;
    logic                wr_go;
    logic                rd_go;
    ioc_pkg::ioc_reg_t   wsel;
    ioc_pkg::ioc_reg_t   rsel;
    logic                fifo_in_ready;
    logic [LW-1:0]       fifo_level;

    function automatic ioc_pkg::ioc_reg_t reg_decode(input logic [ioc_pkg::ADDR_W-1:0] a);
        if (a[ioc_pkg::ADDR_W-1:2] == ioc_pkg::CTRL_OFFS[ioc_pkg::ADDR_W-1:2]) begin
            return ioc_pkg::REG_CTRL;
        end else if (a[ioc_pkg::ADDR_W-1:2] == ioc_pkg::STATUS_OFFS[ioc_pkg::ADDR_W-1:2]) begin
            return ioc_pkg::REG_STATUS;
        end else if (a[ioc_pkg::ADDR_W-1:2] == ioc_pkg::GB_WORD_OFFS[ioc_pkg::ADDR_W-1:2]) begin
            return ioc_pkg::REG_GB;
        end
        return ioc_pkg::REG_NONE;
    endfunction : reg_decode

    // Non right-edge cells have no strobe logic, so memory modes run as generic double rate.
    function automatic logic [1:0] out_mode_eff(input logic [1:0] m);
        if (!RIGHT_EDGE && m == ioc_pkg::OUT_DDR_MEM) begin
            return ioc_pkg::OUT_DDR_GEN;
        end
        return m;
    endfunction : out_mode_eff

    function automatic logic [1:0] in_mode_eff(input logic [1:0] m);
        if (m == ioc_pkg::IN_DDR_MEM) begin
            return RIGHT_EDGE ? ioc_pkg::IN_DDR_MEM : ioc_pkg::IN_DDR_GEN;
        end
        return (m == ioc_pkg::IN_DDR_GEN) ? ioc_pkg::IN_DDR_GEN : ioc_pkg::IN_SDR;
    endfunction : in_mode_eff

    assign link_in.sys_clk   = sys_clk_in;
    assign link_in.edge_clk  = edge_clk_in;
    assign link_in.rd_strobe = read_strobe_shifted;
    assign link_in.wr_strobe = write_strobe_shifted;
    assign link_in.polarity  = sync_clock_polarity;
    assign link_in.pin       = pin_in;

    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
    assign rd_go         = s_axi_arvalid && !q.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign pin_out       = q.pin_out;
    assign pin_oe_n      = !q.out_en;
    assign rise_data_out = q.in_rise;
    assign fall_data_out = q.in_fall;

    always_comb begin
        n = q;
        // Only the second sampling stage and its one-cycle-older copy in prev feed the edge and level logic.
        n.sync1 = link_in;
        n.sync2 = q.sync1;
        n.prev  = q.sync2;
        lv = q.sync2;
        lr = ioc_pkg::ioc_link_t'(q.sync2 & ~q.prev);
        lf = ioc_pkg::ioc_link_t'(~q.sync2 & q.prev);
        omode = out_mode_eff(q.ctrl_out);
        imode = in_mode_eff(q.ctrl_in);
        wsel = reg_decode(s_axi_awaddr);
        rsel = reg_decode(s_axi_araddr);

        // Output path: core data is captured before it can reach the pin.
        if (omode == ioc_pkg::OUT_SDR_LATCH ? lv.sys_clk : lr.sys_clk) begin
            n.rise_hold = rise_data_in;
        end
        if (lr.sys_clk) begin
            n.fall_cap = fall_data_in;
        end
        if (lf.sys_clk) begin
            n.fall_hold = q.fall_cap;
        end
        case (omode)
            ioc_pkg::OUT_SDR_REG,
            ioc_pkg::OUT_SDR_LATCH: begin
                n.pin_out = q.rise_hold;
            end
            ioc_pkg::OUT_DDR_GEN: begin
                n.pin_out = lv.sys_clk ? q.rise_hold : q.fall_hold;
            end
            ioc_pkg::OUT_DDR_MEM: begin
                n.pin_out = lv.wr_strobe ? q.rise_hold : q.fall_hold;
            end
            default: begin
                n.pin_out = q.rise_hold;
            end
        endcase

        // Input path.
        case (imode)
            ioc_pkg::IN_SDR: begin
                if (lr.sys_clk) begin
                    n.in_rise = lv.pin;
                end
            end
            ioc_pkg::IN_DDR_GEN: begin
                if (lr.sys_clk) begin
                    n.in_rise = lv.pin;
                end
                if (lf.sys_clk) begin
                    n.in_fall = lv.pin;
                end
            end
            ioc_pkg::IN_DDR_MEM: begin
                if (lr.rd_strobe) begin
                    n.mem_rise = lv.pin;
                end
                if (lf.rd_strobe) begin
                    n.mem_fall = lv.pin;
                end
                // Picking the far edge gives the strobe data a quarter period to settle.
                if (lv.polarity ? lf.sys_clk : lr.sys_clk) begin
                    n.in_rise = q.mem_rise;
                    n.in_fall = q.mem_fall;
                end
            end
            default: begin
                n.in_rise = q.in_rise;
            end
        endcase

        // Gearbox stage one, two bits per edge clock period.
        if (lr.edge_clk || lf.edge_clk) begin
            n.gb_shift = {q.gb_shift[ioc_pkg::GB_RATIO-1:0], lv.pin};
        end
        // Gearbox stage two, word alignment chosen by the control block.
        if (gb_update) begin
            n.gb_align = align_select ? q.gb_shift[ioc_pkg::GB_RATIO:1]
                                      : q.gb_shift[ioc_pkg::GB_RATIO-1:0];
        end

        // Register writes come before the overflow set so that a new overflow wins over a clear.
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_go) begin
            n.bvalid = 1'b1;
            n.bresp  = ioc_pkg::RESP_OKAY;
            case (wsel)
                ioc_pkg::REG_CTRL: begin
                    if (s_axi_wstrb[0]) begin
                        n.ctrl_out = s_axi_wdata[ioc_pkg::CTRL_OUT_LSB +: 2];
                        n.ctrl_in  = s_axi_wdata[ioc_pkg::CTRL_IN_LSB +: 2];
                        n.out_en   = s_axi_wdata[ioc_pkg::CTRL_OEN_BIT];
                    end
                end
                ioc_pkg::REG_STATUS: begin
                    if (s_axi_wstrb[0] && s_axi_wdata[ioc_pkg::STAT_OVF_BIT]) begin
                        n.overflow = 1'b0;
                    end
                end
                ioc_pkg::REG_GB: begin
                    n.bresp = ioc_pkg::RESP_OKAY;
                end
                default: begin
                    n.bresp = ioc_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Gearbox stage three; a word still waiting for the FIFO makes the stage drop the new word and set overflow.
        if (q.gb_pend && fifo_in_ready) begin
            n.gb_pend = 1'b0;
        end
        if (lr.sys_clk) begin
            if (q.gb_pend && !fifo_in_ready) begin
                n.overflow = 1'b1;
            end else begin
                n.gb_word = q.gb_align;
                n.gb_pend = 1'b1;
            end
        end

        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (rd_go) begin
            n.rvalid = 1'b1;
            n.rresp  = ioc_pkg::RESP_OKAY;
            n.rdata  = '0;
            case (rsel)
                ioc_pkg::REG_CTRL: begin
                    n.rdata[ioc_pkg::CTRL_OUT_LSB +: 2] = q.ctrl_out;
                    n.rdata[ioc_pkg::CTRL_IN_LSB +: 2]  = q.ctrl_in;
                    n.rdata[ioc_pkg::CTRL_OEN_BIT]      = q.out_en;
                end
                ioc_pkg::REG_STATUS: begin
                    n.rdata[ioc_pkg::STAT_PIN_BIT]      = lv.pin;
                    n.rdata[ioc_pkg::STAT_OVF_BIT]      = q.overflow;
                    n.rdata[ioc_pkg::STAT_LVL_LSB +: LW] = fifo_level;
                end
                ioc_pkg::REG_GB: begin
                    n.rdata[ioc_pkg::GB_RATIO-1:0] = q.gb_align;
                end
                default: begin
                    n.rresp = ioc_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q          <= '0;
            q.ctrl_out <= ioc_pkg::CTRL_RESET[ioc_pkg::CTRL_OUT_LSB +: 2];
            q.ctrl_in  <= ioc_pkg::CTRL_RESET[ioc_pkg::CTRL_IN_LSB +: 2];
            q.out_en   <= ioc_pkg::CTRL_RESET[ioc_pkg::CTRL_OEN_BIT];
        end else begin
            q <= n;
        end
    end

    ioc_fifo #(
        .WIDTH (ioc_pkg::GB_RATIO),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_data   (q.gb_word),
        .in_valid  (q.gb_pend),
        .in_ready  (fifo_in_ready),
        .out_data  (gb_data),
        .out_valid (gb_valid),
        .out_ready (gb_ready),
        .level     (fifo_level)
    );

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_sdr_launch;
        omode == ioc_pkg::OUT_SDR_REG && lr.sys_clk;
    endsequence
    sequence s_fall_move;
        omode[1] && lf.sys_clk;
    endsequence
    sequence s_mem_resync;
        imode == ioc_pkg::IN_DDR_MEM && (lv.polarity ? lf.sys_clk : lr.sys_clk);
    endsequence

    sdr_launch_a: assert property (s_sdr_launch ##1 omode == ioc_pkg::OUT_SDR_REG
        |=> pin_out == $past(rise_data_in, 2))
        else $error("single-rate register did not reach the pin two cycles after the edge");
    fall_hold_a: assert property (s_fall_move |=> q.fall_hold == $past(q.fall_cap))
        else $error("fall hold did not take the captured second input");
    ddr_mux_a: assert property (omode == ioc_pkg::OUT_DDR_GEN
        |=> pin_out == ($past(lv.sys_clk) ? $past(q.rise_hold) : $past(q.fall_hold)))
        else $error("generic double-rate mux picked the wrong hold register");
    mem_mux_a: assert property (omode == ioc_pkg::OUT_DDR_MEM
        |=> pin_out == ($past(lv.wr_strobe) ? $past(q.rise_hold) : $past(q.fall_hold)))
        else $error("memory double-rate mux not steered by the write strobe");
    edge_mode_a: assert property (q.ctrl_in == ioc_pkg::IN_DDR_MEM && lr.sys_clk && !lv.polarity
        |=> rise_data_out == (RIGHT_EDGE ? $past(q.mem_rise) : $past(lv.pin)))
        else $error("memory input mode does not match the strobe logic of this cell");
    mem_capture_a: assert property (imode == ioc_pkg::IN_DDR_MEM && lf.rd_strobe
        |=> q.mem_fall == $past(lv.pin))
        else $error("falling read strobe did not sample the pin");
    resync_a: assert property (s_mem_resync |=> rise_data_out == $past(q.mem_rise)
        && fall_data_out == $past(q.mem_fall))
        else $error("strobe streams not moved on the selected system clock edge");
    gb_stage1_a: assert property ((lr.edge_clk || lf.edge_clk) |=> q.gb_shift[0] == $past(lv.pin))
        else $error("gearbox first stage missed an edge clock edge");
    gb_align_a: assert property (gb_update && align_select
        |=> q.gb_align == $past(q.gb_shift[ioc_pkg::GB_RATIO:1]))
        else $error("gearbox alignment ignored the select");
    gb_handoff_a: assert property (lr.sys_clk && !(q.gb_pend && !fifo_in_ready)
        |=> q.gb_pend && q.gb_word == $past(q.gb_align))
        else $error("gearbox third stage did not take the aligned word");
    axi_write_a: assert property (wr_go |=> s_axi_bvalid [*1] ##0 (s_axi_bresp == ioc_pkg::RESP_SLVERR)
        == ($past(wsel) == ioc_pkg::REG_NONE))
        else $error("write response missing or wrong for the address");

endmodule : ioc_gearbox_io

`default_nettype wire

// ==== verilog/ioc_pkg.sv ====
// Shared constants and carrier types for the pin I/O register and input gearbox block.
// Assumes one 250 MHz register clock; every link-side signal is sampled by that clock.
`default_nettype none

package ioc_pkg;

    // Register map, byte addresses on the AXI4-Lite slave.
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] CTRL_OFFS     = 12'h000;
    localparam logic [11:0] STATUS_OFFS   = 12'h004;
    localparam logic [11:0] GB_WORD_OFFS  = 12'h008;

    // Control register fields and value after reset.
    localparam int          CTRL_OUT_LSB  = 0;
    localparam int          CTRL_IN_LSB   = 2;
    localparam int          CTRL_OEN_BIT  = 4;
    localparam logic [4:0]  CTRL_RESET    = 5'h00;

    // Status register fields.
    localparam int          STAT_PIN_BIT  = 0;
    localparam int          STAT_OVF_BIT  = 1;
    localparam int          STAT_LVL_LSB  = 8;

    // Link sampling depth, gearbox ratio and FIFO depth.
    localparam int          SYNC_STAGES   = 2;
    localparam int          GB_RATIO      = 4;
    localparam int          FIFO_DEPTH    = 32;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        OUT_SDR_REG   = 2'h0,
        OUT_SDR_LATCH = 2'h1,
        OUT_DDR_GEN   = 2'h2,
        OUT_DDR_MEM   = 2'h3
    } ioc_out_mode_t;

    typedef enum logic [1:0] {
        IN_SDR     = 2'h0,
        IN_DDR_GEN = 2'h1,
        IN_DDR_MEM = 2'h2
    } ioc_in_mode_t;

    typedef enum logic [3:0] {
        REG_CTRL   = 4'b0001,
        REG_STATUS = 4'b0010,
        REG_GB     = 4'b0100,
        REG_NONE   = 4'b1000
    } ioc_reg_t;

    // Every signal that arrives from outside the register clock domain.
    typedef struct packed {
        logic sys_clk;
        logic edge_clk;
        logic rd_strobe;
        logic wr_strobe;
        logic polarity;
        logic pin;
    } ioc_link_t;

    typedef struct packed {
        ioc_link_t                 sync1;
        ioc_link_t                 sync2;
        ioc_link_t                 prev;
        logic [1:0]                ctrl_out;
        logic [1:0]                ctrl_in;
        logic                      out_en;
        logic                      rise_hold;
        logic                      fall_cap;
        logic                      fall_hold;
        logic                      pin_out;
        logic                      mem_rise;
        logic                      mem_fall;
        logic                      in_rise;
        logic                      in_fall;
        logic [GB_RATIO:0]         gb_shift;
        logic [GB_RATIO-1:0]       gb_align;
        logic [GB_RATIO-1:0]       gb_word;
        logic                      gb_pend;
        logic                      overflow;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } ioc_state_t;

endpackage : ioc_pkg

`default_nettype wire

// ==== verif/ioc_link_model.sv ====
// Far-side double-rate device: free-running system and edge clocks, shifted strobes, pin data.
// Assumes the bench samples every output on its own faster clock.
`default_nettype none
module ioc_link_model (
    // Clocks and strobes.
    output var logic sys_clk_in,
    output var logic edge_clk_in,
    output var logic read_strobe_shifted,
    output var logic write_strobe_shifted,
    // Polarity and data.
    output var logic sync_clock_polarity,
    output var logic pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_q = 3'h0;
    initial begin
        {sys_clk_in, edge_clk_in, read_strobe_shifted, write_strobe_shifted, sync_clock_polarity, pin_in} = 6'h00;
    end
    always #62.5 sys_clk_in = ~sys_clk_in;
    always #15.625 edge_clk_in = ~edge_clk_in;
    // Both strobes trail the system clock by a quarter period.
    always @(sys_clk_in) begin
        read_strobe_shifted  <= #31.25 sys_clk_in;
        write_strobe_shifted <= #31.25 sys_clk_in;
    end
    // Data move well after each edge so no sample lands on a change.
    always @(edge_clk_in) begin
        cnt_q  <= cnt_q + 3'h1;
        pin_in <= #5 cnt_q[0] ^ cnt_q[2];
    end
endmodule : ioc_link_model
`default_nettype wire

// ==== verif/ioc_gearbox_io_tb.sv ====
// Self-checking bench for the pin I/O register and gearbox block, driven over AXI4-Lite.
// Assumes the link model supplies every link clock, strobe and pin level.
`default_nettype none
module ioc_gearbox_io_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, val;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0]  s_axi_wstrb = 4'hF, gb_data;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, rise_data_in = 1'b0, fall_data_in = 1'b0;
    logic        gb_update = 1'b0, align_select = 1'b0, gb_ready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        sys_clk_in, edge_clk_in, read_strobe_shifted, write_strobe_shifted, sync_clock_polarity;
    logic        pin_in, pin_out, pin_oe_n, rise_data_out, fall_data_out, gb_valid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          num_errors = 0, cmp_count = 0;
    ioc_gearbox_io u_dut (.*);
    ioc_link_model u_link (.*);
    always #2 aclk = ~aclk;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready  <= 1'b0;
    endtask : axw
    task automatic axr(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        val = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready  <= 1'b0;
    endtask : axr
    // Checks the pin late in a system clock phase, after the quarter-period write strobe lag has settled.
    task automatic pin_at(input logic lvl, input logic exp);
        @(sys_clk_in iff sys_clk_in === lvl);
        repeat (14) @(posedge aclk);
        cmp(32'(pin_out), 32'(exp));
    endtask : pin_at
    task automatic t_regs();
        cmp(32'(pin_oe_n), 32'h0000_0001);
        axr(ioc_pkg::CTRL_OFFS);
        cmp(val, 32'h0000_0000);
        axr(12'h00C);
        cmp(32'(rsp), 32'(ioc_pkg::RESP_SLVERR));
        axw(ioc_pkg::CTRL_OFFS, 32'h0000_0010);
        axr(ioc_pkg::CTRL_OFFS);
        cmp(val, 32'h0000_0010);
        cmp(32'(pin_oe_n), 32'h0000_0000);
        $display("test regs done");
    endtask : t_regs
    // Every output mode, with the two data inputs set opposite and then swapped.
    task automatic t_out();
        for (int m = 0; m < 4; m++) begin
            axw(ioc_pkg::CTRL_OFFS, 32'h0000_0010 | 32'(m));
            for (int d = 0; d < 2; d++) begin
                rise_data_in <= (d == 0);
                fall_data_in <= (d != 0);
                pin_at(1'b1, d == 0);
                pin_at(1'b0, (d == 0) == (m < 2));
            end
        end
        $display("test out done");
    endtask : t_out
    // Each input mode: the core sees the pin level taken at that mode's capture edge.
    task automatic t_in();
        logic e;
        for (int m = 0; m < 3; m++) begin
            axw(ioc_pkg::CTRL_OFFS, 32'(m) << ioc_pkg::CTRL_IN_LSB);
            if (m == 0) begin
                @(posedge sys_clk_in);
            end else if (m == 1) begin
                @(negedge sys_clk_in);
            end else begin
                @(negedge read_strobe_shifted);
            end
            e = pin_in;
            if (m == 2) begin
                @(posedge sys_clk_in);
            end
            repeat (14) @(posedge aclk);
            cmp(32'(m == 0 ? rise_data_out : fall_data_out), 32'(e));
        end
        $display("test in done");
    endtask : t_in
    // Fill the FIFO past full with the core stalled, then drain it and clear the overflow.
    task automatic t_gear();
        gb_update    <= 1'b1;
        align_select <= 1'b1;
        repeat (1300) @(posedge aclk);
        cmp(32'(gb_valid), 32'h0000_0001);
        axr(ioc_pkg::STATUS_OFFS);
        cmp(val & 32'h0000_3F02, 32'h0000_2002);
        gb_ready <= 1'b1;
        repeat (200) @(posedge aclk);
        axw(ioc_pkg::STATUS_OFFS, 32'h0000_0002);
        axr(ioc_pkg::STATUS_OFFS);
        cmp(val & 32'h0000_3E02, 32'h0000_0000);
        $display("test gear done");
    endtask : t_gear
    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_out();
        t_in();
        t_gear();
        summarize();
    end
    initial begin
        #20000;
        num_errors++;
        summarize();
    end
endmodule : ioc_gearbox_io_tb
`default_nettype wire
